// ==== hw/lmrs_pkg.sv ====
// Constants, types and register map of the LED matrix row scanner

package lmrs_pkg;

  // ----------------------------------------------------------------------
  // Matrix geometry
  // ----------------------------------------------------------------------
  localparam int ROW_TOTAL   = 3;
  localparam int COL_TOTAL   = 3;
  localparam int IMAGE_TOTAL = 4;
  localparam int IMG_W       = ROW_TOTAL * COL_TOTAL;
  localparam int IMG_IDX_W   = 2;
  localparam int ROW_IDX_W   = 2;
  localparam int PORT_W      = 6;
  localparam int COL_LSB     = 3;
  localparam logic [PORT_W-1:0] COL_MASK = 6'h38;
  localparam logic [ROW_TOTAL-1:0] ROWS_OFF = 3'h7;
  localparam logic [ROW_TOTAL-1:0] LINES_DRIVEN = 3'h7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int TICK_TIME_US     = 5000;
  localparam int CLK_PERIOD_NS    = 8;
  localparam int TICK_CYCLES      = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int IMAGE_HOLD_TICKS = 100;
  localparam int CNT_W            = 9;
  localparam logic [CNT_W-1:0] CNT_LIMIT =
    CNT_W'(IMAGE_HOLD_TICKS * IMAGE_TOTAL);

  // ----------------------------------------------------------------------
  // Row state, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [ROW_TOTAL-1:0] {
    ROW_TOP = 3'h1,
    ROW_MID = 3'h2,
    ROW_BOT = 3'h4
  } lmrs_row_t;

  // ----------------------------------------------------------------------
  // Register map, byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PORT   = 8'h08;
  localparam logic [7:0] OFS_IMAGE0 = 8'h0C;
  localparam logic [7:0] OFS_STEP   = 8'h04;
  localparam logic [7:0] OFS_TABLE  = 8'h1C;

  localparam int CTRL_EN_BIT    = 0;
  localparam int STAT_ROW_LSB   = 0;
  localparam int STAT_CNT_LSB   = 8;
  localparam int TABLE_ROW_STEP = COL_TOTAL;

  // Images T, blank, I, blank; row 0 in the low bits, bit 0 right-most
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [IMG_W*IMAGE_TOTAL-1:0] IMAGE_RST =
    {9'h000, 9'h1D7, 9'h000, 9'h097};

endpackage

// ==== hw/lmrs_tick_gen.sv ====
// Periodic tick generator for the LED matrix row scanner
`timescale 1ns/100ps
`default_nettype none

module lmrs_tick_gen #(
  parameter int TICK_CYCLES = lmrs_pkg::TICK_CYCLES,
  parameter int CNT_W       = $clog2(TICK_CYCLES + 1)
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      tick
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_tick;

  // ----------------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------------
  // Held at zero while stopped, so a restart gives a full first period
  always_comb
  begin
    next_count = count;
    next_tick  = 1'b0;
    if (!run)
    begin
      next_count = '0;
    end
    else if (count == LAST)
    begin
      next_count = '0;
      next_tick  = 1'b1;
    end
    else
    begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule

`default_nettype wire

// ==== hw/lmrs_scanner.sv ====
// LED matrix row scanner with APB register access
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module lmrs_scanner #(
  parameter int TICK_CYCLES = lmrs_pkg::TICK_CYCLES,
  parameter int ADDR_W      = 8
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ADDR_W-1:0]              paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic      [lmrs_pkg::ROW_TOTAL-1:0] row_n,
  output logic      [lmrs_pkg::ROW_TOTAL-1:0] row_oe,
  output logic      [lmrs_pkg::COL_TOTAL-1:0] col,
  output logic      [lmrs_pkg::COL_TOTAL-1:0] col_oe
);

  localparam int GAP_W = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [lmrs_pkg::ROW_IDX_W-1:0] row_index(
    input lmrs_pkg::lmrs_row_t s
  );
    case (s)
      lmrs_pkg::ROW_TOP: row_index = 2'h0;
      lmrs_pkg::ROW_MID: row_index = 2'h1;
      lmrs_pkg::ROW_BOT: row_index = 2'h2;
      default:           row_index = 2'h0;
    endcase
  endfunction

  function automatic lmrs_pkg::lmrs_row_t row_after(
    input lmrs_pkg::lmrs_row_t s
  );
    case (s)
      lmrs_pkg::ROW_TOP: row_after = lmrs_pkg::ROW_MID;
      lmrs_pkg::ROW_MID: row_after = lmrs_pkg::ROW_BOT;
      lmrs_pkg::ROW_BOT: row_after = lmrs_pkg::ROW_TOP;
      default:           row_after = lmrs_pkg::ROW_TOP;
    endcase
  endfunction

  // Returns {hit, image index} for a count on an image boundary
  function automatic logic [lmrs_pkg::IMG_IDX_W:0] image_pick(
    input logic [lmrs_pkg::CNT_W-1:0] cnt
  );
    image_pick = '0;
    for (int k = 0; k < lmrs_pkg::IMAGE_TOTAL; k++)
    begin
      if (cnt == lmrs_pkg::CNT_W'((k + 1) * lmrs_pkg::IMAGE_HOLD_TICKS))
      begin
        image_pick = {1'b1, lmrs_pkg::IMG_IDX_W'(k)};
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic                           ctrl_en;
  logic                           next_ctrl_en;
  logic [lmrs_pkg::IMG_W-1:0]     image [lmrs_pkg::IMAGE_TOTAL];
  logic [lmrs_pkg::IMG_W-1:0]     next_image [lmrs_pkg::IMAGE_TOTAL];
  logic [31:0]                    next_prdata;
  logic                           next_pslverr;
  lmrs_pkg::lmrs_row_t            scan_row_state;
  lmrs_pkg::lmrs_row_t            next_scan_row_state;
  logic [lmrs_pkg::ROW_TOTAL-1:0] next_row_n;
  logic [lmrs_pkg::PORT_W-1:0]    col_port;
  logic [lmrs_pkg::PORT_W-1:0]    next_col_port;
  logic [lmrs_pkg::IMG_W-1:0]     pattern_table;
  logic [lmrs_pkg::IMG_W-1:0]     next_pattern_table;
  logic [lmrs_pkg::CNT_W-1:0]     tick_counter;
  logic [lmrs_pkg::CNT_W-1:0]     next_tick_counter;
  logic [lmrs_pkg::CNT_W-1:0]     cnt_inc;
  logic [lmrs_pkg::IMG_IDX_W:0]   pick;
  logic [lmrs_pkg::COL_TOTAL-1:0] cur_pattern;
  logic                           tick;
  logic                           apb_setup;
  logic                           apb_write;
  logic                           wr_port;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign wr_port   = apb_write && (paddr == lmrs_pkg::OFS_PORT);
  assign pready    = 1'b1;
  assign cur_pattern = pattern_table[row_index(scan_row_state) *
                       lmrs_pkg::TABLE_ROW_STEP +: lmrs_pkg::COL_TOTAL];
  // Lines never float, so the matrix sees no ghosting from open pins
  assign row_oe = lmrs_pkg::LINES_DRIVEN;
  assign col_oe = lmrs_pkg::LINES_DRIVEN;
  assign col    = col_port[lmrs_pkg::COL_LSB +: lmrs_pkg::COL_TOTAL];

  lmrs_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ctrl_en),
    .tick    (tick)
  );

  // ----------------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------------
  // Read data is latched in the setup cycle; answer has no wait states
  always_comb
  begin
    next_ctrl_en = ctrl_en;
    next_image   = image;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (apb_write && paddr == lmrs_pkg::OFS_CTRL)
    begin
      next_ctrl_en = pwdata[lmrs_pkg::CTRL_EN_BIT];
    end
    for (int k = 0; k < lmrs_pkg::IMAGE_TOTAL; k++)
    begin
      if (apb_write && paddr == ADDR_W'(lmrs_pkg::OFS_IMAGE0 +
          lmrs_pkg::OFS_STEP * k))
      begin
        next_image[k] = pwdata[lmrs_pkg::IMG_W-1:0];
      end
    end
    if (apb_setup)
    begin
      next_prdata  = '0;
      next_pslverr = 1'b0;
      case (paddr)
        lmrs_pkg::OFS_CTRL:
          next_prdata[lmrs_pkg::CTRL_EN_BIT] = ctrl_en;
        lmrs_pkg::OFS_STATUS:
        begin
          next_prdata[lmrs_pkg::STAT_ROW_LSB +: lmrs_pkg::ROW_TOTAL] =
            scan_row_state;
          next_prdata[lmrs_pkg::STAT_CNT_LSB +: lmrs_pkg::CNT_W] =
            tick_counter;
        end
        lmrs_pkg::OFS_PORT:
          next_prdata[lmrs_pkg::PORT_W-1:0] = col_port;
        lmrs_pkg::OFS_TABLE:
          next_prdata[lmrs_pkg::IMG_W-1:0] = pattern_table;
        default:
        begin
          next_pslverr = 1'b1;
          for (int k = 0; k < lmrs_pkg::IMAGE_TOTAL; k++)
          begin
            if (paddr == ADDR_W'(lmrs_pkg::OFS_IMAGE0 +
                lmrs_pkg::OFS_STEP * k))
            begin
              next_pslverr = 1'b0;
              next_prdata[lmrs_pkg::IMG_W-1:0] = image[k];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_en <= lmrs_pkg::CTRL_EN_RST;
      for (int k = 0; k < lmrs_pkg::IMAGE_TOTAL; k++)
      begin
        image[k] <= lmrs_pkg::IMAGE_RST[k*lmrs_pkg::IMG_W +: lmrs_pkg::IMG_W];
      end
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl_en <= next_ctrl_en;
      image   <= next_image;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------------
  // Row scan, column port, pattern table and tick counter
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_scan_row_state = scan_row_state;
    next_row_n          = row_n;
    next_col_port       = col_port;
    next_pattern_table  = pattern_table;
    next_tick_counter   = tick_counter;
    cnt_inc             = tick_counter + 1'b1;
    pick                = image_pick(cnt_inc);
    // Software owns only the bits outside the column mask
    if (wr_port)
    begin
      next_col_port = (pwdata[lmrs_pkg::PORT_W-1:0] & ~lmrs_pkg::COL_MASK) |
                      (col_port & lmrs_pkg::COL_MASK);
    end
    if (!ctrl_en)
    begin
      // Stopped: a row left lit would overdrive its LEDs
      next_row_n    = lmrs_pkg::ROWS_OFF;
      next_col_port = next_col_port & ~lmrs_pkg::COL_MASK;
    end
    else if (tick)
    begin
      // Select current row, release the one before
      next_row_n = ~scan_row_state;
      // A one bit drives its column high
      next_col_port = (next_col_port & ~lmrs_pkg::COL_MASK) |
                      ((lmrs_pkg::PORT_W'(cur_pattern) << lmrs_pkg::COL_LSB)
                       & lmrs_pkg::COL_MASK);
      next_scan_row_state = row_after(scan_row_state);
      if (cnt_inc > lmrs_pkg::CNT_LIMIT)
      begin
        next_tick_counter = '0;
      end
      else
      begin
        next_tick_counter = cnt_inc;
      end
      if (pick[lmrs_pkg::IMG_IDX_W])
      begin
        next_pattern_table = image[pick[lmrs_pkg::IMG_IDX_W-1:0]];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_row_state <= lmrs_pkg::ROW_TOP;
      row_n          <= lmrs_pkg::ROWS_OFF;
      col_port       <= '0;
      pattern_table  <= '0;
      tick_counter   <= '0;
    end
    else
    begin
      scan_row_state <= next_scan_row_state;
      row_n          <= next_row_n;
      col_port       <= next_col_port;
      pattern_table  <= next_pattern_table;
      tick_counter   <= next_tick_counter;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [GAP_W-1:0] tick_gap;
  logic             tick_seen;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_gap  <= '0;
      tick_seen <= 1'b0;
    end
    else
    begin
      tick_gap  <= (tick || !ctrl_en) ? '0 : tick_gap + 1'b1;
      tick_seen <= ctrl_en && (tick_seen || tick);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_scan_step;
    tick && ctrl_en;
  endsequence

  sequence s_step_from(lmrs_pkg::lmrs_row_t r);
    s_scan_step ##0 (scan_row_state == r);
  endsequence

  AST_TICK_PERIOD: assert property (
    (tick && ctrl_en && tick_seen) |-> tick_gap == GAP_W'(TICK_CYCLES - 1))
    else $error("tick spacing differs from the tick period");

  AST_ONE_ROW: assert property ($onehot0(~row_n))
    else $error("more than one row selected");

  AST_ROW_SELECT: assert property (
    s_scan_step |=> row_n == ~$past(scan_row_state))
    else $error("row lines do not select the stepped row");

  AST_ROW_ORDER: assert property (
    s_step_from(lmrs_pkg::ROW_TOP) |=> scan_row_state == lmrs_pkg::ROW_MID)
    else $error("top row not followed by middle row");

  AST_ROW_WRAP: assert property (
    s_step_from(lmrs_pkg::ROW_BOT) |=> scan_row_state == lmrs_pkg::ROW_TOP)
    else $error("bottom row does not wrap to top row");

  AST_COL_LOAD: assert property (
    s_scan_step |=> col == $past(cur_pattern))
    else $error("columns do not show the row pattern");

  AST_PORT_KEEP: assert property (
    !wr_port |=> (col_port & ~lmrs_pkg::COL_MASK) ==
                 $past(col_port & ~lmrs_pkg::COL_MASK))
    else $error("port bits outside the column mask changed");

  AST_CNT_INC: assert property (
    (s_scan_step ##0 (tick_counter < lmrs_pkg::CNT_LIMIT))
      |=> tick_counter == $past(tick_counter) + 1'b1)
    else $error("tick counter did not advance by one");

  AST_CNT_HOLD: assert property (
    !(tick && ctrl_en) |=> $stable(tick_counter))
    else $error("tick counter moved without a tick");

  AST_CNT_WRAP: assert property (
    (s_scan_step ##0 (tick_counter >= lmrs_pkg::CNT_LIMIT))
      |=> tick_counter == '0)
    else $error("tick counter did not restart");

  AST_TABLE_LOAD: assert property (
    (s_scan_step ##0 (tick_counter ==
      lmrs_pkg::CNT_W'(lmrs_pkg::IMAGE_HOLD_TICKS - 1)))
      |=> pattern_table == image[0])
    else $error("first image not loaded at its boundary");

  AST_RESET_IDLE: assert property (
    $rose(presetn) |-> row_n == lmrs_pkg::ROWS_OFF &&
      scan_row_state == lmrs_pkg::ROW_TOP)
    else $error("scanner not idle after reset");

endmodule

`default_nettype wire

// ==== dv/lmrs_matrix_model.sv ====
// Passive three by three LED matrix seen from the scanner's pins
`timescale 1ns/100ps
`default_nettype none

module lmrs_matrix_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] row_n,
  input  wire logic [2:0] row_oe,
  input  wire logic [2:0] col,
  input  wire logic [2:0] col_oe,
  output logic      [8:0] lit,
  output logic            overlap
);
  // ----------------------------------------------------------------------
  // Diodes conduct only with a driven low cathode and driven high anode
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int r = 0; r < 3; r++)
    begin
      for (int c = 0; c < 3; c++)
      begin
        lit[3*r+c] = row_oe[r] & ~row_n[r] & col_oe[c] & col[c];
      end
    end
  end

  // Sticky, so a one-cycle glitch between rows is never missed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overlap <= 1'b0;
    else if ((row_oe & ~row_n) inside {3'h3, 3'h5, 3'h6, 3'h7})
      overlap <= 1'b1;
  end
endmodule

`default_nettype wire

// ==== dv/lmrs_scanner_tb_top.sv ====
// Self-checking testbench of the LED matrix row scanner
`timescale 1ns/100ps
`default_nettype none

module lmrs_scanner_tb_top;
  // Short tick so a full image sequence fits in the run
  localparam int TC = 64;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  row_n;
  logic [2:0]  row_oe;
  logic [2:0]  col;
  logic [2:0]  col_oe;
  logic [8:0]  lit;
  logic        overlap;
  logic [31:0] q;
  logic        e;
  int          errors   = 0;
  int          compares = 0;

  always #4 pclk = ~pclk;

  lmrs_scanner #(.TICK_CYCLES(TC), .ADDR_W(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .row_n(row_n), .row_oe(row_oe),
    .col(col), .col_oe(col_oe));

  lmrs_matrix_model u_matrix (
    .pclk(pclk), .presetn(presetn), .row_n(row_n), .row_oe(row_oe),
    .col(col), .col_oe(col_oe), .lit(lit), .overlap(overlap));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends on pready; only the watchdog ends a wait that never sees it
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for the next row change; a missing change is a mismatch
  task automatic step;
    logic [2:0] prev;
    int         n;
    prev = row_n;
    n    = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end while (row_n === prev && n < 3*TC);
    chk({31'h0, row_n === prev}, 32'h0);
  endtask

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    #1;
    chk(row_n, 3'h7);
    chk(col, 3'h0);
    chk(row_oe, 3'h7);
    chk(col_oe, 3'h7);
    apb(1'b0, lmrs_pkg::OFS_STATUS, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, lmrs_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, lmrs_pkg::OFS_IMAGE0 + 8'h08, 32'h0);
    chk(q, 32'h1D7);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask

  // Every tick for a whole image sequence and past the counter wrap
  task automatic t_scan;
    logic [8:0] img [4];
    logic [8:0] tbl;
    logic [8:0] el;
    logic [2:0] er;
    int         sr;
    int         cnt;
    time        tl;
    for (int i = 0; i < 4; i++)
      img[i] = lmrs_pkg::IMAGE_RST[9*i +: 9];
    tbl = 9'h000;
    sr  = 0;
    cnt = 0;
    for (int k = 1; k <= 410; k++)
    begin
      step;
      if (k > 1) chk(32'(($time - tl) / 8), 32'(TC));
      tl = $time;
      er = ~(3'h1 << sr);
      el = {6'h00, tbl[3*sr +: 3]} << (3*sr);
      chk(row_n, er);
      chk(col, tbl[3*sr +: 3]);
      chk(lit, el);
      sr  = (sr == 2) ? 0 : sr + 1;
      cnt = (cnt + 1 > 400) ? 0 : cnt + 1;
      if (cnt != 0 && cnt % 100 == 0)
        tbl = img[cnt/100 - 1];
      if (k == 103)
      begin
        apb(1'b0, lmrs_pkg::OFS_TABLE, 32'h0);
        chk(q, 32'h097);
        apb(1'b1, lmrs_pkg::OFS_PORT, 32'h05);
        apb(1'b0, lmrs_pkg::OFS_PORT, 32'h0);
        chk(q, 32'h3D);
      end
      // Stop: rows released, columns dark, row state and counter held
      if (k == 120)
      begin
        apb(1'b1, lmrs_pkg::OFS_CTRL, 32'h0);
        @(posedge pclk);
        #1;
        chk(row_n, 3'h7);
        chk(col, 3'h0);
        repeat (2*TC) @(posedge pclk);
        #1;
        chk(lit, 9'h000);
        apb(1'b0, lmrs_pkg::OFS_STATUS, 32'h0);
        chk(q, 32'((cnt << 8) | (1 << sr)));
        apb(1'b0, lmrs_pkg::OFS_PORT, 32'h0);
        chk(q, 32'h05);
        apb(1'b1, lmrs_pkg::OFS_CTRL, 32'h1);
        // Timer restarts at zero: next row comes TC + 1 cycles on
        tl = $time + 9;
      end
      if (k == 150)
      begin
        apb(1'b1, lmrs_pkg::OFS_IMAGE0 + 8'h04, 32'h155);
        img[1] = 9'h155;
      end
    end
    apb(1'b0, lmrs_pkg::OFS_STATUS, 32'h0);
    chk(q, 32'((cnt << 8) | (1 << sr)));
    chk({31'h0, overlap}, 32'h0);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_scan;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    finish_test;
  end

  initial
  begin
    repeat (60000) @(posedge pclk);
    errors++;
    finish_test;
  end
endmodule

`default_nettype wire
